// [bench/conv_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Converter core stand-in
// Answers each start once, after one cycle or after a long wait. Outside the
// done pulse the data bus shows the inverse of its last value, so a result
// latched at the wrong moment cannot pass by luck.
module conv_core_model
    import adc_seq_pkg::*;
(
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire conv_req_t conv_req,
    input  wire logic      slow,
    output var  logic      conv_done,
    output var  logic [9:0] conv_data
);
    logic [5:0] seq_r;
    logic [5:0] wait_r;
    logic [3:0] src_r;
    logic       busy_r;

    always @(posedge aclk)
    begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (!aresetn)
        begin
            busy_r    <= 1'b0;
            seq_r     <= 6'h00;
            conv_data <= 10'h155;
        end
        else if (conv_req.start)
        begin
            busy_r <= 1'b1;
            src_r  <= conv_req.source;
            wait_r <= slow ? 6'h18 : 6'h00;
        end
        else if (busy_r && wait_r != 6'h00)
            wait_r <= wait_r - 6'h01;
        else if (busy_r)
        begin
            busy_r    <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= {src_r, seq_r};
            seq_r     <= seq_r + 6'h01;
        end
    end
endmodule : conv_core_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import adc_seq_pkg::*;
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] insel;
        logic [7:0] refb;
        logic [7:0] tsel;
        logic [2:0] slot;
        logic [3:0] src;
    } row_t;
    // ==========================================================
    // Signals
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, timer1_trig, timer2_trig, ext_trig_n, conv_done, conv_irq;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, x;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [9:0]  conv_data, e10;
    conv_req_t   conv_req;
    int          num_errors = 0, check_count = 0, n_start = 0, n_done = 0, cycles = 0;
    int          bs, bd, slots;
    logic [3:0]  src_log [0:15];
    row_t        rows [0:4];

    adc_mode_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer1_trig, .timer2_trig, .ext_trig_n,
        .conv_req, .conv_done, .conv_data, .conv_irq);
    conv_core_model core_model (.aclk, .aresetn, .conv_req, .slow, .conv_done, .conv_data);

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // ==========================================================
    // Observation and hang guard
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (conv_req.start === 1'b1)
        begin
            src_log[n_start % 16] <= conv_req.source;
            n_start <= n_start + 1;
        end
        if (conv_done === 1'b1)
            n_done <= n_done + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // A released payload shows its inverse, so a slave that reads it late is caught.
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!w && s_axi_wready === 1'b1)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~{24'h0, v};
            end
        end
        s_axi_bready <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_bvalid !== 1'b1);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        axi_wr(a, v, RESP_OKAY);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check({30'h0, s_axi_rresp}, {30'h0, er});
        check(d, exp);
    endtask : rd_chk

    // The first sample is taken one edge after entry, so a pulse that was just
    // seen by the previous call is never counted twice.
    task automatic wait_irq(input int lim, input logic [31:0] exp);
        int k;
        k = 0;
        do
        begin
            @(posedge aclk);
            k++;
        end
        while (conv_irq !== 1'b1 && k < lim);
        check({31'h0, k < lim}, exp);
    endtask : wait_irq

    task automatic pulse_trig(input logic [1:0] t);
        timer1_trig <= (t == TRIG_TIMER1);
        timer2_trig <= (t == TRIG_TIMER2);
        ext_trig_n <= (t != TRIG_EXT);
        @(posedge aclk);
        timer1_trig <= 1'b0;
        timer2_trig <= 1'b0;
        ext_trig_n <= 1'b1;
    endtask : pulse_trig

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // Main sequence
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {timer1_trig, timer2_trig, slow, aresetn} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        ext_trig_n = 1'b1;
        s_axi_wstrb = 4'hF;
        rows[0] = '{8'h40, 8'h03, 8'h00, 8'h00, 3'h3, 4'h3};
        rows[1] = '{8'h00, 8'h36, 8'h00, 8'h00, 3'h6, 4'h6};
        rows[2] = '{8'h50, 8'h02, 8'h01, 8'h00, 3'h0, 4'h7};
        rows[3] = '{8'h60, 8'h05, 8'h00, 8'h03, 3'h5, 4'h8};
        rows[4] = '{8'h70, 8'h01, 8'h00, 8'h01, 3'h1, 4'h1};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++)
        begin
            wr(OFS_INSEL, rows[i].insel);
            wr(OFS_CTRL_B, rows[i].refb);
            wr(OFS_CTRL_C, rows[i].tsel);
            wr(OFS_MODE, rows[i].mode);
            bd = n_done;
            wr(OFS_CTRL_A, 8'h01);
            pulse_trig(rows[i].mode[5:4]);
            wait_irq(200, 32'h1);
            check({31'h0, conv_req.res10}, {31'h0, rows[i].mode[6]});
            e10 = {rows[i].src, bd[5:0]};
            x = rows[i].mode[6] ? {22'h0, e10} : {24'h0, e10[9:2]};
            rd_chk(OFS_RESULT + {3'h0, rows[i].slot, 2'h0}, RESP_OKAY, x);
            rd_chk(OFS_CTRL_A, RESP_OKAY, {31'h0, rows[i].mode[5:4] != TRIG_SW});
            wr(OFS_CTRL_A, 8'h00);
        end
        $display("test one_shot_rows done");
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_C, 8'h00);
        wr(OFS_INSEL, 8'h04);
        wr(OFS_MODE, 8'h41);
        bs = n_start;
        wr(OFS_CTRL_A, 8'h01);
        wait_irq(80, 32'h0);
        check({31'h0, n_start - bs > 3}, 32'h1);
        rd_chk(OFS_CTRL_A, RESP_OKAY, 32'h1);
        wr(OFS_CTRL_A, 8'h00);
        repeat (2) @(posedge aclk);
        bs = n_start;
        repeat (30) @(posedge aclk);
        check(n_start - bs, 32'h0);
        $display("test repeat0 done");
        slow <= 1'b1;
        wr(OFS_INSEL, 8'h01);
        wr(OFS_MODE, 8'h42);
        bs = n_start;
        bd = n_done;
        wr(OFS_CTRL_A, 8'h01);
        wait_irq(400, 32'h1);
        check(n_done - bd, 32'h8);
        repeat (3) @(posedge aclk);
        check(n_start - bs, 32'h9);
        wr(OFS_CTRL_A, 8'h00);
        wait_irq(60, 32'h0);
        for (int j = 0; j < 8; j++)
            rd_chk(OFS_RESULT + 8'(4 * j), RESP_OKAY, {22'h0, 4'h1, 6'(bd + j)});
        $display("test repeat1 done");
        slow <= 1'b0;
        wr(OFS_MODE, 8'h43);
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_INSEL, {2'(c), 6'h00});
            slots = (c == 3) ? 8 : 2 * (c + 1);
            bs = n_start;
            bd = n_done;
            wr(OFS_CTRL_A, 8'h01);
            wait_irq(200, 32'h1);
            repeat (20) @(posedge aclk);
            check(n_start - bs, 32'(slots));
            for (int j = 0; j < slots; j++)
                check({28'h0, src_log[(bs + j) % 16]}, (j == 7) ? 32'hF : 32'(j));
            rd_chk(OFS_CTRL_A, RESP_OKAY, 32'h0);
            for (int j = 0; j < slots && j < 7; j++)
                rd_chk(OFS_RESULT + 8'(4 * j), RESP_OKAY, {22'h0, 4'(j), 6'(bd + j)});
        end
        $display("test single_sweep done");
        wr(OFS_INSEL, 8'h00);
        wr(OFS_MODE, 8'h44);
        bs = n_start;
        wr(OFS_CTRL_A, 8'h01);
        wait_irq(100, 32'h1);
        wait_irq(100, 32'h1);
        for (int j = 0; j < 4; j++)
            check({28'h0, src_log[(bs + j) % 16]}, 32'(j % 2));
        wr(OFS_CTRL_A, 8'h00);
        $display("test repeat_sweep done");
        slow <= 1'b1;
        wr(OFS_MODE, 8'h40);
        wr(OFS_CTRL_A, 8'h01);
        repeat (5) @(posedge aclk);
        wr(OFS_CTRL_A, 8'h00);
        wait_irq(60, 32'h0);
        $display("test abort done");
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(OFS_MODE, RESP_OKAY, 32'h0);
        rd_chk(OFS_STATUS, RESP_OKAY, 32'h0);
        rd_chk(OFS_RESULT + 8'h0C, RESP_OKAY, 32'h0);
        rd_chk(8'h18, RESP_SLVERR, 32'h0);
        axi_wr(8'h18, 8'hFF, RESP_SLVERR);
        $display("test reset_and_unmapped done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire

// [hdl/adc_mode_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_mode_sequencer
    import adc_seq_pkg::*;
#(
    parameter int RESULTS = 8
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        timer1_trig,
    input  wire logic        timer2_trig,
    input  wire logic        ext_trig_n,
    output var  conv_req_t   conv_req,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_data,
    output var  logic        conv_irq
);
    // ==========================================================
    // Helpers
    function automatic logic [2:0] sweep_last(input logic [1:0] cnt);
        case (cnt)
            SWEEP_2: sweep_last = 3'h1;
            SWEEP_4: sweep_last = 3'h3;
            SWEEP_6: sweep_last = 3'h5;
            default: sweep_last = 3'h7;
        endcase
    endfunction : sweep_last

    function automatic logic is_sweep(input logic [2:0] m);
        is_sweep = (m == MODE_SINGLE_SWEEP) || (m == MODE_REPEAT_SWEEP);
    endfunction : is_sweep

    // ==========================================================
    // Register bus
    logic        aw_have_r;
    logic        w_have_r;
    logic [7:0]  awaddr_q_r;
    logic [31:0] wdata_q_r;
    logic [3:0]  wstrb_q_r;
    logic        go_r;
    logic [7:0]  mode_reg_r;
    logic [7:0]  insel_r;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  ctrl_c_r;
    seq_state_t  state_r;
    logic [2:0]  rot_r;
    logic [2:0]  idx_r;
    logic        ext_prev_r;
    logic [9:0]  result_mem [RESULTS];

    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    wire lane0    = wstrb_q_r[0];
    wire wr_ctrl  = do_write && lane0 && (awaddr_q_r == OFS_CTRL_A);
    wire wr_mode  = do_write && lane0 && (awaddr_q_r == OFS_MODE);
    wire wr_insel = do_write && lane0 && (awaddr_q_r == OFS_INSEL);
    wire wr_ctrlb = do_write && lane0 && (awaddr_q_r == OFS_CTRL_B);
    wire wr_ctrlc = do_write && lane0 && (awaddr_q_r == OFS_CTRL_C);
    wire wr_hit   = (awaddr_q_r <= OFS_STATUS) && (awaddr_q_r[1:0] == 2'b00);
    wire ar_take  = s_axi_arvalid && s_axi_arready;
    wire rd_res   = (s_axi_araddr[7:5] == OFS_RESULT[7:5]) && (s_axi_araddr[1:0] == 2'b00);
    wire [2:0] rd_ix = s_axi_araddr[4:2];

    // Software stopping by go=0 is the abort path.
    wire abort    = wr_ctrl && !wdata_q_r[GO_BIT] && (state_r != S_IDLE);
    wire go_start = wr_ctrl && wdata_q_r[GO_BIT] && (state_r == S_IDLE);

    wire [2:0] mode     = mode_reg_r[MODE_LSB +: 3];
    wire [1:0] trig_sel = mode_reg_r[TRIG_LSB +: 2];
    wire       res10    = mode_reg_r[RES10_BIT];
    wire [2:0] chan     = insel_r[CH_LSB +: 3];
    wire [1:0] sweep_n  = insel_r[SWEEP_LSB +: 2];
    wire       temp_sel = ctrl_c_r[TS_ROUTE_BIT] && ctrl_c_r[TS_PICK_BIT];
    wire       ref_sel  = ctrl_b_r[REF_BIT];

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (rd_res)
            rd_mux = {22'h000000, result_mem[rd_ix]};
        else
            case (s_axi_araddr)
                OFS_CTRL_A: rd_mux = {31'h0000_0000, go_r};
                OFS_MODE:   rd_mux = {24'h000000, mode_reg_r};
                OFS_INSEL:  rd_mux = {24'h000000, insel_r};
                OFS_CTRL_B: rd_mux = {24'h000000, ctrl_b_r};
                OFS_CTRL_C: rd_mux = {24'h000000, ctrl_c_r};
                OFS_STATUS: rd_mux = {24'h000000, idx_r, rot_r, state_r};
                default:    rd_mux = 32'h0000_0000;
            endcase
    end
    wire rd_hit = rd_res || (s_axi_araddr <= OFS_STATUS && s_axi_araddr[1:0] == 2'b00);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_q_r    <= 8'h00;
            wdata_q_r     <= 32'h0000_0000;
            wstrb_q_r     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                awaddr_q_r <= s_axi_awaddr;
                aw_have_r  <= 1'b1;
            end
            if (w_take)
            begin
                wdata_q_r <= s_axi_wdata;
                wstrb_q_r <= s_axi_wstrb;
                w_have_r  <= 1'b1;
            end
            if (do_write)
            begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_awready <= !(aw_have_r || aw_take) || do_write;
            s_axi_wready  <= !(w_have_r || w_take) || do_write;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    // Configuration is meant to be written while stopped; nothing blocks a
    // write during conversion, it takes effect at once, also on the completion in progress.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_reg_r <= REG_RST;
            insel_r    <= REG_RST;
            ctrl_b_r   <= REG_RST;
            ctrl_c_r   <= REG_RST;
        end
        else
        begin
            if (wr_mode)
                mode_reg_r <= wdata_q_r[7:0];
            if (wr_insel)
                insel_r <= wdata_q_r[7:0];
            if (wr_ctrlb)
                ctrl_b_r <= wdata_q_r[7:0];
            if (wr_ctrlc)
                ctrl_c_r <= wdata_q_r[7:0];
        end
    end

    // ==========================================================
    // Triggers and source selection
    wire ext_fall = ext_prev_r && !ext_trig_n;
    logic trig_hit;
    always_comb
    begin
        case (trig_sel)
            TRIG_SW:     trig_hit = 1'b1;
            TRIG_TIMER1: trig_hit = timer1_trig;
            TRIG_TIMER2: trig_hit = timer2_trig;
            TRIG_EXT:    trig_hit = ext_fall;
            default:     trig_hit = 1'b0;
        endcase
    end

    wire [3:0] single_src = temp_sel ? SRC_TEMP : (ref_sel ? SRC_REF : {1'b0, chan});
    wire [2:0] single_dst = (!temp_sel && ref_sel) ? 3'h0 : chan;
    wire       sweeping   = is_sweep(mode);
    wire       in_conv    = (state_r == S_CONV);
    wire       done_ok    = in_conv && conv_done && !abort;
    wire       last_slot  = (idx_r == sweep_last(sweep_n));
    wire [2:0] nxt_idx    = last_slot ? 3'h0 : idx_r + 3'h1;
    wire [3:0] sweep_src  = (nxt_idx == 3'h7) ? SRC_DUMMY : {1'b0, nxt_idx};

    // Result destination and value for the conversion that completes now.
    logic [2:0] dst_w;
    logic       store_w;
    always_comb
    begin
        dst_w   = single_dst;
        store_w = done_ok;
        case (mode)
            MODE_REPEAT1: dst_w = rot_r;
            MODE_SINGLE_SWEEP, MODE_REPEAT_SWEEP:
            begin
                dst_w   = idx_r;
                store_w = done_ok && (idx_r != 3'h7);
            end
            default: dst_w = single_dst;
        endcase
    end
    wire [9:0] store_val = res10 ? conv_data : {2'b00, conv_data[9:2]};

    // End of operation with this completion, and interrupt for it.
    logic fin_w;
    logic irq_w;
    always_comb
    begin
        fin_w = 1'b0;
        irq_w = 1'b0;
        case (mode)
            MODE_REPEAT0: irq_w = 1'b0;
            MODE_REPEAT1: irq_w = done_ok && (rot_r == 3'h7);
            MODE_SINGLE_SWEEP:
            begin
                irq_w = done_ok && last_slot;
                fin_w = done_ok && last_slot;
            end
            MODE_REPEAT_SWEEP: irq_w = done_ok && last_slot;
            default:
            begin
                irq_w = done_ok;
                fin_w = done_ok;
            end
        endcase
    end
    wire go_hw_clr = fin_w && (sweeping || trig_sel == TRIG_SW);

    // ==========================================================
    // Sequencer
    seq_state_t state_nxt;
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:  if (go_start) state_nxt = S_ARMED;
            S_ARMED: state_nxt = abort ? S_IDLE : (trig_hit ? S_CONV : S_ARMED);
            S_CONV:
            begin
                if (abort)
                    state_nxt = S_IDLE;
                else if (fin_w)
                    state_nxt = go_hw_clr ? S_IDLE : S_ARMED;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // Repeat modes restart without a new trigger; only go=0 ends them.
    wire restart  = done_ok && !fin_w;
    wire start_go = (state_r == S_ARMED && state_nxt == S_CONV) || restart;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r    <= S_IDLE;
            go_r       <= 1'b0;
            rot_r      <= 3'h0;
            idx_r      <= 3'h0;
            ext_prev_r <= 1'b1;
            conv_req   <= '0;
            conv_irq   <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            ext_prev_r <= ext_trig_n;
            conv_irq   <= irq_w;
            if (wr_ctrl)
                go_r <= wdata_q_r[GO_BIT];
            else if (go_hw_clr)
                go_r <= 1'b0;
            if (go_start)
            begin
                rot_r <= 3'h0;
                idx_r <= 3'h0;
            end
            else if (done_ok && mode == MODE_REPEAT1)
                rot_r <= rot_r + 3'h1;
            else if (done_ok && sweeping)
                idx_r <= nxt_idx;
            conv_req.start <= start_go;
            conv_req.res10 <= res10;
            if (start_go)
                conv_req.source <= sweeping ? (restart ? sweep_src : 4'h0) : single_src;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < RESULTS; i++)
                result_mem[i] <= 10'h000;
        end
        else if (store_w)
            result_mem[dst_w] <= store_val;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_rep0_irq_quiet: assert property ((mode == MODE_REPEAT0) && $past(mode == MODE_REPEAT0)
        |-> !conv_irq) else $error("repeat mode 0 raised an interrupt");
    a_oneshot_irq: assert property ((mode == MODE_ONE_SHOT) && done_ok |=> conv_irq)
        else $error("one-shot completion without interrupt");
    a_sw_go_clear: assert property ((mode == MODE_ONE_SHOT) && (trig_sel == TRIG_SW)
        && done_ok |=> !go_r && state_r == S_IDLE)
        else $error("software one-shot left go set");
    a_abort_halts: assert property (abort |=> state_r == S_IDLE && !conv_irq && !conv_req.start)
        else $error("go cleared but operation continued");
    a_rep1_wrap_irq: assert property ((mode == MODE_REPEAT1) && done_ok && rot_r == 3'h7
        |=> conv_irq && rot_r == 3'h0 && conv_req.start && state_r == S_CONV)
        else $error("repeat mode 1 wrap wrong");
    a_rep1_rotate: assert property ((mode == MODE_REPEAT1) && done_ok && rot_r != 3'h7
        |=> rot_r == $past(rot_r) + 3'h1 && !conv_irq)
        else $error("repeat mode 1 rotation wrong");
    a_sweep_order: assert property (sweeping && done_ok && !last_slot
        |=> idx_r == $past(idx_r) + 3'h1 && conv_req.start)
        else $error("sweep did not advance to next input");
    a_single_sweep_end: assert property ((mode == MODE_SINGLE_SWEEP) && done_ok && last_slot
        |=> !go_r ##0 conv_irq ##1 state_r == S_IDLE)
        else $error("single sweep did not stop");
    a_seven_eight: assert property (sweeping && sweep_n == SWEEP_7 && done_ok && idx_r == 3'h6
        |=> !conv_irq && conv_req.source == SRC_DUMMY)
        else $error("seven-input sweep skipped eighth slot");
    a_result_store: assert property (store_w |=> result_mem[$past(dst_w)] == $past(store_val))
        else $error("result not stored");
    a_rsweep_restart: assert property ((mode == MODE_REPEAT_SWEEP) && done_ok && last_slot
        |=> idx_r == 3'h0 && conv_req.source == 4'h0 && conv_req.start)
        else $error("repeat sweep did not restart");

    c_oneshot: cover property ((mode == MODE_ONE_SHOT) && done_ok ##1 conv_irq);
    c_rep1_wrap: cover property ((mode == MODE_REPEAT1) && done_ok && rot_r == 3'h7);
    c_rsweep_pass: cover property ((mode == MODE_REPEAT_SWEEP) && done_ok && last_slot);
    c_abort: cover property (abort && in_conv);
endmodule : adc_mode_sequencer
`default_nettype wire

// [hdl/adc_seq_pkg.sv]
package adc_seq_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_MODE   = 8'h04;
    localparam logic [7:0] OFS_INSEL  = 8'h08;
    localparam logic [7:0] OFS_CTRL_B = 8'h0C;
    localparam logic [7:0] OFS_CTRL_C = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h20;
    // ==========================================================
    // Field positions
    localparam int GO_BIT       = 0;
    localparam int MODE_LSB     = 0;
    localparam int TRIG_LSB     = 4;
    localparam int RES10_BIT    = 6;
    localparam int CH_LSB       = 0;
    localparam int GRP_LSB      = 4;
    localparam int SWEEP_LSB    = 6;
    localparam int REF_BIT      = 0;
    localparam int TS_ROUTE_BIT = 0;
    localparam int TS_PICK_BIT  = 1;
    localparam logic [7:0] REG_RST = 8'h00;
    // ==========================================================
    // Encodings
    localparam logic [2:0] MODE_ONE_SHOT     = 3'h0;
    localparam logic [2:0] MODE_REPEAT0      = 3'h1;
    localparam logic [2:0] MODE_REPEAT1      = 3'h2;
    localparam logic [2:0] MODE_SINGLE_SWEEP = 3'h3;
    localparam logic [2:0] MODE_REPEAT_SWEEP = 3'h4;
    localparam logic [1:0] TRIG_SW     = 2'h0;
    localparam logic [1:0] TRIG_TIMER1 = 2'h1;
    localparam logic [1:0] TRIG_TIMER2 = 2'h2;
    localparam logic [1:0] TRIG_EXT    = 2'h3;
    localparam logic [1:0] SWEEP_2 = 2'h0;
    localparam logic [1:0] SWEEP_4 = 2'h1;
    localparam logic [1:0] SWEEP_6 = 2'h2;
    localparam logic [1:0] SWEEP_7 = 2'h3;
    localparam logic [3:0] SRC_REF   = 4'h7;
    localparam logic [3:0] SRC_TEMP  = 4'h8;
    localparam logic [3:0] SRC_DUMMY = 4'hF;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_ARMED = 2'b01,
        S_CONV  = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic       start;
        logic       res10;
        logic [3:0] source;
    } conv_req_t;
endpackage : adc_seq_pkg
